// ===== uart_status_pkg.sv
// Contract
// - line status bit 2 flags a parity fault on the head received character.
// - line status bit 1 sets when a character completes while the store is full, unless a receive read frees a slot in that cycle.
// - on overrun the new character is dropped; stored characters stay intact.
// - line status bit 0 is high while any received character is held.
// - modem status address reads modem status; writes go to extra feature control.
// - any modem status read clears all four change flags, except a flag whose new edge arrives in the read cycle.
// - modem status bit 7 is inverted carrier detect, or user output two in loopback.
// - modem status bit 6 is inverted ring indicator, or user output one in loopback.
// - modem status bit 5 is inverted data set ready, or terminal ready in loopback.
// - modem status bit 4 is inverted clear to send, or request to send in loopback.
// - change flags 3, 1, 0 set on any toggle of their input since last read.
// - ring change flag 2 sets only when the ring input rises from 0 to 1.
// - a modem status interrupt request stands, one cycle late, while any change flag is set.
`default_nettype none
package uart_status_pkg;

  // ==========================================================
  // register offsets on the host bus
  localparam logic [2:0] RX_DATA_OFFSET       = 3'h0;
  localparam logic [2:0] MODEM_CONTROL_OFFSET = 3'h4;
  localparam logic [2:0] LINE_STATUS_OFFSET   = 3'h5;
  localparam logic [2:0] MODEM_STATUS_OFFSET  = 3'h6;

  // ==========================================================
  // line status field positions
  localparam int LS_READY   = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY  = 2;

  // ==========================================================
  // modem control field positions
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;

  // ==========================================================
  // change flag positions inside the low nibble of modem status
  localparam int MS_CTS_CHANGE = 0;
  localparam int MS_DSR_CHANGE = 1;
  localparam int MS_RI_CHANGE  = 2;
  localparam int MS_CD_CHANGE  = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] EXTRA_FEATURE_RESET = 8'h00;
  localparam logic [7:0] READ_DATA_RESET     = 8'h00;
  localparam logic [3:0] MODEM_LIVE_RESET    = 4'h0;

  // ==========================================================
  // receive store geometry
  localparam int RX_DEPTH = 128;
  localparam int RX_PTR_W = 7;
  localparam int RX_CNT_W = 8;
  localparam logic [RX_CNT_W-1:0] RX_FULL_COUNT = 8'h80;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [2:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       valid;
    logic       parity_bad;
    logic [7:0] data;
  } rx_char_t;

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } modem_pins_t;

endpackage
`default_nettype wire

// ===== uart_rx_store.sv
`timescale 1ns/10ps
`default_nettype none
module uart_rx_store (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    fifo_mode,
  input  wire logic                    flush,
  input  wire uart_status_pkg::rx_char_t in_char,
  input  wire logic                    pop,
  output logic                         empty,
  output logic                         full,
  output logic                         overrun,
  output logic [7:0]                   head_data,
  output logic                         head_parity_bad
);

  logic [8:0]                             mem [uart_status_pkg::RX_DEPTH];
  logic [uart_status_pkg::RX_PTR_W-1:0]   wr_ptr;
  logic [uart_status_pkg::RX_PTR_W-1:0]   rd_ptr;
  logic [uart_status_pkg::RX_CNT_W-1:0]   count;
  logic                                   do_push;
  logic                                   do_pop;

  // one entry in holding mode, full depth in fifo mode
  assign empty = (count == '0);
  assign full  = fifo_mode ? (count == uart_status_pkg::RX_FULL_COUNT) : !empty;
  assign do_pop  = pop && !empty;
  assign do_push = in_char.valid && (!full || do_pop);
  assign overrun = in_char.valid && full && !do_pop;
  assign head_data       = mem[rd_ptr][7:0];
  assign head_parity_bad = !empty && mem[rd_ptr][8];

  // storage; an overrunning character is never written
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= {in_char.parity_bad, in_char.data};
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 7'h01;
      end
      if (do_push && !do_pop) begin
        count <= count + 8'h01;
      end else if (do_pop && !do_push) begin
        count <= count - 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ===== uart_modem_change.sv
`timescale 1ns/10ps
`default_nettype none
module uart_modem_change (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] live,
  input  wire logic       clear,
  output logic [3:0]      flags
);

  logic      [3:0] prev;
  logic      [1:0] primed;
  wire logic [3:0] edge_seen;

  // live lags the pins by one stage, so two cycles after reset only load references
  always_ff @(posedge clk) begin
    if (reset) begin
      prev   <= 4'h0;
      primed <= 2'h0;
    end else begin
      prev   <= live;
      primed <= {primed[0], 1'b1};
    end
  end

  // edge detection, one per modem input
  for (genvar i = 0; i < 4; i++) begin : g_flag
    if (i == uart_status_pkg::MS_RI_CHANGE) begin : g_ri
      // ring pin rising means the inverted status bit falls
      assign edge_seen[i] = primed[1] && prev[i] && !live[i];
    end else begin : g_any
      assign edge_seen[i] = primed[1] && (prev[i] ^ live[i]);
    end
  end

  // sticky flags; a new edge beats the read clear
  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~{4{clear}}) | edge_seen;
    end
  end

endmodule
`default_nettype wire

// ===== uart_line_modem_status.sv
`timescale 1ns/10ps
`default_nettype none
module uart_line_modem_status (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire uart_status_pkg::host_req_t   host_req,
  input  wire uart_status_pkg::rx_char_t    rx_char,
  input  wire logic                         fifo_mode,
  input  wire uart_status_pkg::modem_pins_t modem_pins,
  output logic [7:0]                        rd_data,
  output logic                              modem_status_irq,
  output logic                              rx_ready,
  output logic                              dtr_n,
  output logic                              rts_n,
  output logic                              user_output_one_n,
  output logic                              user_output_two_n,
  output logic                              loopback,
  output logic [7:0]                        extra_feature_control
);

  // ==========================================================
  // internal state

  logic [7:0] modem_control;
  logic [3:0] modem_live;
  logic [3:0] next_modem_live;
  logic [3:0] change_flags;
  logic       overrun_flag;
  logic       fifo_mode_q;
  logic       mode_flush;

  logic       store_empty;
  logic       store_full;
  logic       store_overrun;
  logic [7:0] store_head_data;
  logic       store_head_parity;

  logic       read_rx;
  logic       read_line_status;
  logic       read_modem_status;
  logic       write_modem_control;
  logic       write_extra_feature;

  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [7:0] next_rd_data;

  // ==========================================================
  // host bus decode

  // one-cycle read and write strobes qualified by address
  assign read_rx = host_req.rd
    && (host_req.addr == uart_status_pkg::RX_DATA_OFFSET);
  assign read_line_status = host_req.rd
    && (host_req.addr == uart_status_pkg::LINE_STATUS_OFFSET);
  assign read_modem_status = host_req.rd
    && (host_req.addr == uart_status_pkg::MODEM_STATUS_OFFSET);
  assign write_modem_control = host_req.wr
    && (host_req.addr == uart_status_pkg::MODEM_CONTROL_OFFSET);
  assign write_extra_feature = host_req.wr
    && (host_req.addr == uart_status_pkg::MODEM_STATUS_OFFSET);

  // ==========================================================
  // writable registers

  // modem control: outputs, user outputs and loopback select
  always_ff @(posedge clk) begin
    if (reset) begin
      modem_control <= uart_status_pkg::MODEM_CONTROL_RESET;
    end else if (write_modem_control) begin
      modem_control <= host_req.wdata;
    end
  end

  // a write at the modem status address lands here instead
  always_ff @(posedge clk) begin
    if (reset) begin
      extra_feature_control <= uart_status_pkg::EXTRA_FEATURE_RESET;
    end else if (write_extra_feature) begin
      extra_feature_control <= host_req.wdata;
    end
  end

  // ==========================================================
  // receive store

  // switching between holding and fifo mode empties the store
  always_ff @(posedge clk) begin
    if (reset) begin
      fifo_mode_q <= 1'b0;
    end else begin
      fifo_mode_q <= fifo_mode;
    end
  end

  assign mode_flush = fifo_mode_q ^ fifo_mode;

  uart_rx_store u_rx_store (
    .clk             (clk),
    .reset           (reset),
    .fifo_mode       (fifo_mode),
    .flush           (mode_flush),
    .in_char         (rx_char),
    .pop             (read_rx),
    .empty           (store_empty),
    .full            (store_full),
    .overrun         (store_overrun),
    .head_data       (store_head_data),
    .head_parity_bad (store_head_parity)
  );

  // ==========================================================
  // overrun flag

  // sticky until line status is read; a new overrun beats the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      overrun_flag <= 1'b0;
    end else if (store_overrun) begin
      overrun_flag <= 1'b1;
    end else if (read_line_status) begin
      overrun_flag <= 1'b0;
    end
  end

  // ==========================================================
  // line status composition

  // upper bits belong to other logic and read as zero here
  always_comb begin
    line_status = 8'h00;
    line_status[uart_status_pkg::LS_READY]   = !store_empty;
    line_status[uart_status_pkg::LS_OVERRUN] = overrun_flag;
    line_status[uart_status_pkg::LS_PARITY]  = store_head_parity;
  end

  // ==========================================================
  // modem status live bits

  // order in the nibble: cd, ri, dsr, cts (status bits 7 to 4)
  always_comb begin
    if (modem_control[uart_status_pkg::MC_LOOP]) begin
      next_modem_live[3] = modem_control[uart_status_pkg::MC_OUT2];
      next_modem_live[2] = modem_control[uart_status_pkg::MC_OUT1];
      next_modem_live[1] = modem_control[uart_status_pkg::MC_DTR];
      next_modem_live[0] = modem_control[uart_status_pkg::MC_RTS];
    end else begin
      next_modem_live[3] = !modem_pins.cd_n;
      next_modem_live[2] = !modem_pins.ri_n;
      next_modem_live[1] = !modem_pins.dsr_n;
      next_modem_live[0] = !modem_pins.cts_n;
    end
  end

  // pins are taken as synchronous; one stage aligns them with the flags
  always_ff @(posedge clk) begin
    if (reset) begin
      modem_live <= uart_status_pkg::MODEM_LIVE_RESET;
    end else begin
      modem_live <= next_modem_live;
    end
  end

  // ==========================================================
  // change flags

  uart_modem_change u_modem_change (
    .clk   (clk),
    .reset (reset),
    .live  (modem_live),
    .clear (read_modem_status),
    .flags (change_flags)
  );

  assign modem_status = {modem_live, change_flags};

  // ==========================================================
  // read data

  // unmapped addresses answer zero
  always_comb begin
    next_rd_data = rd_data;
    if (host_req.rd) begin
      case (host_req.addr)
        uart_status_pkg::RX_DATA_OFFSET: begin
          next_rd_data = store_head_data;
        end
        uart_status_pkg::MODEM_CONTROL_OFFSET: begin
          next_rd_data = modem_control;
        end
        uart_status_pkg::LINE_STATUS_OFFSET: begin
          next_rd_data = line_status;
        end
        uart_status_pkg::MODEM_STATUS_OFFSET: begin
          next_rd_data = modem_status;
        end
        default: begin
          next_rd_data = 8'h00;
        end
      endcase
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= uart_status_pkg::READ_DATA_RESET;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ==========================================================
  // registered status outputs

  // interrupt request follows the flags one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      modem_status_irq <= 1'b0;
    end else begin
      modem_status_irq <= |change_flags;
    end
  end

  // data ready level for the datapath and interrupt logic
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= !store_empty;
    end
  end

  // ==========================================================
  // modem control pins

  // active-low pins are the inverse of their control bits
  always_ff @(posedge clk) begin
    if (reset) begin
      dtr_n             <= 1'b1;
      rts_n             <= 1'b1;
      user_output_one_n <= 1'b1;
      user_output_two_n <= 1'b1;
      loopback          <= 1'b0;
    end else begin
      dtr_n             <= !modem_control[uart_status_pkg::MC_DTR];
      rts_n             <= !modem_control[uart_status_pkg::MC_RTS];
      user_output_one_n <= !modem_control[uart_status_pkg::MC_OUT1];
      user_output_two_n <= !modem_control[uart_status_pkg::MC_OUT2];
      loopback          <= modem_control[uart_status_pkg::MC_LOOP];
    end
  end

endmodule
`default_nettype wire

// ===== uart_status_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// checker on the status block ports
module uart_status_monitor (
  input wire logic                         clk,
  input wire logic                         reset,
  input wire uart_status_pkg::host_req_t   host_req,
  input wire uart_status_pkg::rx_char_t    rx_char,
  input wire logic                         fifo_mode,
  input wire uart_status_pkg::modem_pins_t modem_pins,
  input wire logic [7:0]                   rd_data,
  input wire logic                         modem_status_irq,
  input wire logic                         rx_ready,
  input wire logic                         dtr_n,
  input wire logic                         rts_n,
  input wire logic                         user_output_one_n,
  input wire logic                         user_output_two_n,
  input wire logic                         loopback,
  input wire logic [7:0]                   extra_feature_control
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // decoded host accesses
  logic rd5;
  logic rd6;
  logic wr6;
  assign rd5 = host_req.rd && host_req.addr == uart_status_pkg::LINE_STATUS_OFFSET;
  assign rd6 = host_req.rd && host_req.addr == uart_status_pkg::MODEM_STATUS_OFFSET;
  assign wr6 = host_req.wr && host_req.addr == uart_status_pkg::MODEM_STATUS_OFFSET;

  // ==========
  // assertions
  chk_efc_write: assert property (wr6 |=> extra_feature_control == $past(host_req.wdata))
    else $error("extra feature control missed a write");
  chk_efc_hold: assert property (!wr6 |=> $stable(extra_feature_control))
    else $error("extra feature control changed without a write");
  chk_ms_pins: assert property (rd6 && !loopback |=> rd_data[7:4] == ~$past(modem_pins, 2))
    else $error("modem status upper bits differ from inverted pins");
  chk_ms_loop: assert property (rd6 && loopback |=> rd_data[7:4] ==
    ~$past({user_output_two_n, user_output_one_n, dtr_n, rts_n}))
    else $error("modem status upper bits differ from loopback sources");
  chk_irq_flags: assert property (rd6 && modem_status_irq && !$past(rd6) |=> rd_data[3:0] != 4'h0)
    else $error("interrupt raised with no change flag");
  chk_read_clears: assert property (rd6 && $stable(modem_pins) && $past($stable(modem_pins))
    && !$past(host_req.wr) && !$past(host_req.wr, 2) |=> ##1 !modem_status_irq)
    else $error("change flags survived a modem status read");
  chk_rx_ready: assert property (rx_char.valid && $stable(fifo_mode) ##1 $stable(fifo_mode)
    |=> rx_ready)
    else $error("ready missing after a received character");
  chk_ls_ready: assert property (rd5 |=> rd_data[0] == rx_ready && rd_data[7:3] == 5'h00)
    else $error("line status ready bit wrong");
  // main scenarios reached
  cover property (rd6 ##1 rd_data[3:0] != 4'h0);
  cover property (rd5 ##1 rd_data[1]);
  cover property (rd6 && loopback);
endmodule
`default_nettype wire

// ===== modem_peer.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// modem side: drives the active-low control inputs after a chosen lag
module modem_peer (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [3:0]                  want,
  input  wire logic [3:0]                  lag,
  output var uart_status_pkg::modem_pins_t pins
);
  logic [3:0] wait_cnt;
  // inactive high after reset; new levels appear once the lag has run out
  always_ff @(posedge clk) begin
    if (reset) begin
      pins     <= 4'hf;
      wait_cnt <= 4'h0;
    end else if (pins == want) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag) begin
      pins     <= want;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [2:0] RX = uart_status_pkg::RX_DATA_OFFSET;
  localparam logic [2:0] MC = uart_status_pkg::MODEM_CONTROL_OFFSET;
  localparam logic [2:0] LS = uart_status_pkg::LINE_STATUS_OFFSET;
  localparam logic [2:0] MS = uart_status_pkg::MODEM_STATUS_OFFSET;
  logic                         clk;
  logic                         reset;
  logic                         fifo_mode;
  uart_status_pkg::host_req_t   host_req;
  uart_status_pkg::rx_char_t    rx_char;
  uart_status_pkg::modem_pins_t modem_pins;
  logic [3:0]                   want;
  logic [3:0]                   lag;
  logic [7:0]                   rd_data;
  logic [7:0]                   efc;
  logic                         irq;
  logic                         rx_ready;
  logic                         dtr_n;
  logic                         rts_n;
  logic                         out1_n;
  logic                         out2_n;
  logic                         loopback;
  logic [7:0]                   d;
  int                           n_fail;
  int                           compares;

  // ==========
  // design, modem side and clock
  uart_line_modem_status DUT (.clk(clk), .reset(reset), .host_req(host_req), .rx_char(rx_char),
    .fifo_mode(fifo_mode), .modem_pins(modem_pins), .rd_data(rd_data), .modem_status_irq(irq),
    .rx_ready(rx_ready), .dtr_n(dtr_n), .rts_n(rts_n), .user_output_one_n(out1_n),
    .user_output_two_n(out2_n), .loopback(loopback), .extra_feature_control(efc));
  modem_peer peer (.clk(clk), .reset(reset), .want(want), .lag(lag), .pins(modem_pins));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========
  // shared tasks
  task automatic report_and_stop;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge clk);
    #1 host_req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(posedge clk);
    #1 host_req.rd = 1'b0;
    q = rd_data;
  endtask
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 host_req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: v};
    @(posedge clk);
    #1 host_req.wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus_rd(a, q);
    check(q, exp);
  endtask
  task automatic push(input logic [7:0] v, input logic bad);
    @(posedge clk);
    #1 rx_char = '{valid: 1'b1, parity_bad: bad, data: v};
    @(posedge clk);
    #1 rx_char.valid = 1'b0;
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    rd_chk(LS, 8'h00);
    rd_chk(MS, 8'h00);
    check({7'h00, irq}, 8'h00);
    check(efc, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_change;
    int k;
    lag = 4'h3;
    for (int i = 0; i < 3; i++) begin
      k = (i == 2) ? 3 : i;
      want[k] = 1'b0;
      cycles(10);
      check({7'h00, irq}, 8'h01);
      rd_chk(MS, 8'h11 << k);
      want[k] = 1'b1;
      cycles(10);
      rd_chk(MS, 8'h01 << k);
      cycles(2);
      check({7'h00, irq}, 8'h00);
    end
    want[2] = 1'b0;
    cycles(10);
    check({7'h00, irq}, 8'h00);
    rd_chk(MS, 8'h40);
    want[2] = 1'b1;
    cycles(10);
    rd_chk(MS, 8'h04);
    $display("test modem change done");
  endtask
  task automatic t_same_cycle;
    lag = 4'h0;
    want[0] = 1'b0;
    @(posedge clk);
    bus_rd(MS, d);
    rd_chk(MS, 8'h11);
    want[0] = 1'b1;
    cycles(10);
    rd_chk(MS, 8'h01);
    $display("test same cycle done");
  endtask
  task automatic t_loop;
    logic [7:0] v;
    logic [7:0] tbl [4] = '{8'h1f, 8'h19, 8'h16, 8'h10};
    foreach (tbl[i]) begin
      v = tbl[i];
      bus_wr(MC, v);
      cycles(4);
      bus_rd(MS, d);
      check({4'h0, d[7:4]}, {4'h0, v[3], v[2], v[0], v[1]});
      check({4'h0, out2_n, out1_n, rts_n, dtr_n}, {4'h0, ~v[3:0]});
      check({7'h00, loopback}, {7'h00, v[4]});
    end
    bus_wr(MC, 8'h00);
    cycles(4);
    bus_rd(MS, d);
    rd_chk(MS, 8'h00);
    $display("test loopback done");
  endtask
  task automatic t_efc;
    bus_wr(MS, 8'ha5);
    check(efc, 8'ha5);
    rd_chk(MS, 8'h00);
    bus_wr(3'h7, 8'h3c);
    rd_chk(3'h7, 8'h00);
    check(efc, 8'ha5);
    $display("test shared address done");
  endtask
  task automatic t_holding;
    fifo_mode = 1'b0;
    cycles(2);
    push(8'h3c, 1'b1);
    push(8'hc3, 1'b0);
    cycles(2);
    check({7'h00, rx_ready}, 8'h01);
    rd_chk(LS, 8'h07);
    rd_chk(RX, 8'h3c);
    rd_chk(LS, 8'h00);
    check({7'h00, rx_ready}, 8'h00);
    $display("test holding done");
  endtask
  task automatic t_fifo;
    fifo_mode = 1'b1;
    cycles(2);
    for (int i = 0; i <= uart_status_pkg::RX_DEPTH; i++) push(8'(i), i == 0);
    cycles(2);
    rd_chk(LS, 8'h07);
    rd_chk(RX, 8'h00);
    rd_chk(LS, 8'h01);
    for (int i = 1; i < uart_status_pkg::RX_DEPTH; i++) rd_chk(RX, 8'(i));
    rd_chk(LS, 8'h00);
    $display("test fifo done");
  endtask

  // ==========
  // watchdog and main sequence
  initial begin
    #500000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    host_req = '0;
    rx_char = '0;
    fifo_mode = 1'b0;
    want = 4'hf;
    lag = 4'h0;
    n_fail = 0;
    compares = 0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    cycles(2);
    t_reset;
    t_change;
    t_same_cycle;
    t_loop;
    t_efc;
    t_holding;
    t_fifo;
    report_and_stop;
  end
endmodule
bind uart_line_modem_status uart_status_monitor mon (.clk(clk), .reset(reset),
  .host_req(host_req), .rx_char(rx_char), .fifo_mode(fifo_mode), .modem_pins(modem_pins),
  .rd_data(rd_data), .modem_status_irq(modem_status_irq), .rx_ready(rx_ready), .dtr_n(dtr_n),
  .rts_n(rts_n), .user_output_one_n(user_output_one_n), .user_output_two_n(user_output_two_n),
  .loopback(loopback), .extra_feature_control(extra_feature_control));
`default_nettype wire
